/* hw/scv_pkg.sv */
package scv_pkg;
  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int unsigned CLK_HZ = 10_000_000;
  localparam int unsigned MEAS_MS = 35;
  localparam int unsigned MEAS_CYC = CLK_HZ / 1000 * MEAS_MS;
  localparam int unsigned WIN_MS = 100;
  localparam logic [1:0] WIN_MEAS = 2'((WIN_MS + MEAS_MS - 1) / MEAS_MS);
  localparam int unsigned LIM0_MS = 350;
  localparam int unsigned LIM1_MS = 560;
  localparam int unsigned LIM2_MS = 770;
  localparam int unsigned LIM3_MS = 980;
  localparam logic [4:0] LIM0_MEAS = 5'(LIM0_MS / MEAS_MS);
  localparam logic [4:0] LIM1_MEAS = 5'(LIM1_MS / MEAS_MS);
  localparam logic [4:0] LIM2_MEAS = 5'(LIM2_MS / MEAS_MS);
  localparam logic [4:0] LIM3_MEAS = 5'(LIM3_MS / MEAS_MS);

  // ----------------------------------------
  // Register indexes, byte address is index times four
  // ----------------------------------------
  localparam int unsigned ADDR_W = 10;
  localparam logic [7:0] IDX_LID4 = 8'h3d;
  localparam logic [7:0] IDX_SPEED = 8'h3e;
  localparam logic [7:0] IDX_RECAL = 8'h3f;
  localparam logic [7:0] IDX_IRQ_STAT = 8'h50;
  localparam logic [7:0] IDX_IRQ_MASK = 8'h51;
  localparam logic [7:0] IDX_LID_STAT = 8'h52;
  localparam logic [7:0] IDX_RPT_RATE = 8'h53;

  // ----------------------------------------
  // Reset values
  // ----------------------------------------
  localparam logic [7:0] SPEED_RST = 8'hc5;
  localparam logic [7:0] RECAL_RST = 8'h00;
  localparam logic [7:0] LID4_RST = 8'h0a;
  localparam logic [3:0] MASK_RST = 4'h0;
  localparam logic [7:0] RPT_RATE_RST = 8'h03;

  // ----------------------------------------
  // Interrupt status bits and bus answers
  // ----------------------------------------
  localparam int unsigned IRQ_EXTRA = 0;
  localparam int unsigned IRQ_RPT = 1;
  localparam int unsigned IRQ_LID = 2;
  localparam int unsigned IRQ_RECAL = 3;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ----------------------------------------
  // Types
  // ----------------------------------------
  typedef struct packed {
    logic accel_extra_irq_enable;
    logic [2:0] max_extra_irq;
    logic [1:0] slide_time_limit;
    logic [1:0] repeat_speedup_scale;
  } scv_speed_cfg_s;

  typedef struct packed {
    logic [3:0] unused;
    logic [1:0] lid_frac_sensor_fourteen;
    logic [1:0] lid_frac_sensor_thirteen;
  } scv_lid_cfg_s;

  typedef struct packed {
    logic valid;
    logic [3:0] sensor;
    logic [7:0] delta;
    logic [6:0] thr;
  } scv_meas_s;

  typedef struct packed {
    logic step;
    logic hold;
    logic done;
  } scv_slide_s;

  typedef enum logic [1:0] {SL_IDLE, SL_RUN, SL_EMIT} scv_slide_e;
endpackage : scv_pkg

/* hw/scv_tick.sv */
`timescale 1ns/10ps
`default_nettype none
module scv_tick #(
  parameter int unsigned DIV = 4
) (
  // Clock and reset
  input wire logic i_sys_clk,
  input wire logic i_rst,
  // Enable pulse
  output logic o_tick
);
  localparam int unsigned CW = (DIV > 1) ? $clog2(DIV) : 1;
  logic [CW-1:0] cnt_r;
  logic [CW-1:0] cnt_nxt;
  logic tick_nxt;

  always_comb begin
    tick_nxt = (cnt_r == CW'(DIV - 1));
    cnt_nxt = tick_nxt ? '0 : cnt_r + 1'b1;
  end

  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      cnt_r <= '0;
      o_tick <= 1'b0;
    end else begin
      cnt_r <= cnt_nxt;
      o_tick <= tick_nxt;
    end
  end
endmodule : scv_tick
`default_nettype wire

/* hw/scv_recal_bit.sv */
`timescale 1ns/10ps
`default_nettype none
module scv_recal_bit (
  // Clock and reset
  input wire logic i_sys_clk,
  input wire logic i_rst,
  // Request and completion
  input wire logic i_set,
  input wire logic i_done,
  output logic o_busy
);
  logic busy_nxt;

  // Software set wins over completion, writing zero does nothing
  always_comb begin
    busy_nxt = o_busy;
    if (i_done) begin
      busy_nxt = 1'b0;
    end
    if (i_set) begin
      busy_nxt = 1'b1;
    end
  end

  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      o_busy <= 1'b0;
    end else begin
      o_busy <= busy_nxt;
    end
  end
endmodule : scv_recal_bit
`default_nettype wire

/* hw/scv_slider_ctrl.sv */
`timescale 1ns/10ps
`default_nettype none
module scv_slider_ctrl #(
  parameter int unsigned MEAS_CYCLES = scv_pkg::MEAS_CYC
) (
  // Clock and reset
  input wire logic i_sys_clk,
  input wire logic i_rst,
  // AXI4-Lite write
  input wire logic i_awvalid,
  output logic o_awready,
  input wire logic [scv_pkg::ADDR_W-1:0] i_awaddr,
  input wire logic i_wvalid,
  output logic o_wready,
  input wire logic [31:0] i_wdata,
  input wire logic [3:0] i_wstrb,
  output logic o_bvalid,
  input wire logic i_bready,
  output logic [1:0] o_bresp,
  // AXI4-Lite read
  input wire logic i_arvalid,
  output logic o_arready,
  input wire logic [scv_pkg::ADDR_W-1:0] i_araddr,
  output logic o_rvalid,
  input wire logic i_rready,
  output logic [31:0] o_rdata,
  output logic [1:0] o_rresp,
  // Measurement front end
  input wire scv_pkg::scv_meas_s i_meas,
  input wire scv_pkg::scv_slide_s i_slide,
  input wire logic [7:0] i_recal_done,
  output logic [7:0] o_recal_req,
  output logic [7:0] o_repeat_cycles,
  output logic o_slide_irq,
  // Interrupt
  output logic o_irq
);
  // ----------------------------------------
  // Declarations
  // ----------------------------------------
  logic aw_v_r, aw_v_nxt, w_v_r, w_v_nxt, w_s_r, w_s_nxt;
  logic [7:0] aw_i_r, aw_i_nxt, w_d_r, w_d_nxt;
  logic b_v_nxt, r_v_nxt;
  logic [1:0] b_resp_nxt, r_resp_nxt;
  logic [7:0] r_d_r, r_d_nxt;
  logic wr_en, wr_ok;
  logic [7:0] ar_idx;
  scv_pkg::scv_speed_cfg_s speed_r, speed_nxt;
  scv_pkg::scv_lid_cfg_s lid4_r, lid4_nxt;
  logic [3:0] mask_r, mask_nxt, irq_st_r, irq_st_nxt, ev;
  logic [7:0] rpt_r, rpt_nxt, recal_set;
  logic [1:0] lid_st_r, lid_st_nxt, lid_hit;
  logic [7:0] lid_thr;
  logic tick;
  scv_pkg::scv_slide_e st_r, st_nxt;
  logic [4:0] t_r, t_nxt, lim;
  logic [2:0] left_r, left_nxt;
  logic [1:0] win_r, win_nxt;
  logic [2:0] cnt_r, cnt_nxt, spd_r, spd_nxt;
  logic [7:0] iv_nxt, rc_r, rc_nxt;
  logic extra_ev, rpt_ev, recal_fin;

  function automatic logic mapped(input logic [7:0] idx);
    case (idx)
      scv_pkg::IDX_LID4, scv_pkg::IDX_SPEED, scv_pkg::IDX_RECAL, scv_pkg::IDX_IRQ_STAT,
      scv_pkg::IDX_IRQ_MASK, scv_pkg::IDX_LID_STAT, scv_pkg::IDX_RPT_RATE: return 1'b1;
      default: return 1'b0;
    endcase
  endfunction : mapped

  // ----------------------------------------
  // AXI4-Lite slave
  // ----------------------------------------
  assign o_awready = ~aw_v_r;
  assign o_wready = ~w_v_r;
  assign o_arready = ~o_rvalid;
  assign wr_en = aw_v_r & w_v_r & ~o_bvalid;
  assign wr_ok = wr_en & w_s_r & mapped(aw_i_r);
  assign ar_idx = i_araddr[9:2];
  assign o_rdata = {24'h000000, r_d_r};

  always_comb begin
    aw_v_nxt = aw_v_r;
    aw_i_nxt = aw_i_r;
    w_v_nxt = w_v_r;
    w_d_nxt = w_d_r;
    w_s_nxt = w_s_r;
    b_v_nxt = o_bvalid;
    b_resp_nxt = o_bresp;
    r_v_nxt = o_rvalid;
    r_d_nxt = r_d_r;
    r_resp_nxt = o_rresp;
    if (i_awvalid && !aw_v_r) begin
      aw_v_nxt = 1'b1;
      aw_i_nxt = i_awaddr[9:2];
    end
    if (i_wvalid && !w_v_r) begin
      w_v_nxt = 1'b1;
      w_d_nxt = i_wdata[7:0];
      w_s_nxt = i_wstrb[0];
    end
    if (o_bvalid && i_bready) begin
      b_v_nxt = 1'b0;
    end
    if (wr_en) begin
      aw_v_nxt = 1'b0;
      w_v_nxt = 1'b0;
      b_v_nxt = 1'b1;
      b_resp_nxt = mapped(aw_i_r) ? scv_pkg::RESP_OKAY : scv_pkg::RESP_SLVERR;
    end
    if (o_rvalid && i_rready) begin
      r_v_nxt = 1'b0;
    end
    if (i_arvalid && !o_rvalid) begin
      r_v_nxt = 1'b1;
      r_resp_nxt = mapped(ar_idx) ? scv_pkg::RESP_OKAY : scv_pkg::RESP_SLVERR;
      case (ar_idx)
        scv_pkg::IDX_LID4: r_d_nxt = {4'h0, lid4_r[3:0]};
        scv_pkg::IDX_SPEED: r_d_nxt = speed_r;
        scv_pkg::IDX_RECAL: r_d_nxt = o_recal_req;
        scv_pkg::IDX_IRQ_STAT: r_d_nxt = {4'h0, irq_st_r};
        scv_pkg::IDX_IRQ_MASK: r_d_nxt = {4'h0, mask_r};
        scv_pkg::IDX_LID_STAT: r_d_nxt = {6'h00, lid_st_r};
        scv_pkg::IDX_RPT_RATE: r_d_nxt = rpt_r;
        default: r_d_nxt = 8'h00;
      endcase
    end
  end

  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      aw_v_r <= 1'b0;
      aw_i_r <= 8'h00;
      w_v_r <= 1'b0;
      w_d_r <= 8'h00;
      w_s_r <= 1'b0;
      o_bvalid <= 1'b0;
      o_bresp <= scv_pkg::RESP_OKAY;
      o_rvalid <= 1'b0;
      r_d_r <= 8'h00;
      o_rresp <= scv_pkg::RESP_OKAY;
    end else begin
      aw_v_r <= aw_v_nxt;
      aw_i_r <= aw_i_nxt;
      w_v_r <= w_v_nxt;
      w_d_r <= w_d_nxt;
      w_s_r <= w_s_nxt;
      o_bvalid <= b_v_nxt;
      o_bresp <= b_resp_nxt;
      o_rvalid <= r_v_nxt;
      r_d_r <= r_d_nxt;
      o_rresp <= r_resp_nxt;
    end
  end

  // ----------------------------------------
  // Registers, lid detection and interrupts
  // ----------------------------------------
  always_comb begin
    unique case (lid4_r.lid_frac_sensor_thirteen)
      2'h0: lid_thr = 8'({1'b0, i_meas.thr} >> 4);
      2'h1: lid_thr = 8'({1'b0, i_meas.thr} >> 3);
      2'h2: lid_thr = 8'({1'b0, i_meas.thr} >> 2);
      2'h3: lid_thr = 8'({1'b0, i_meas.thr} >> 1);
    endcase
    if (i_meas.sensor == 4'he) begin
      unique case (lid4_r.lid_frac_sensor_fourteen)
        2'h0: lid_thr = 8'({1'b0, i_meas.thr} >> 4);
        2'h1: lid_thr = 8'({1'b0, i_meas.thr} >> 3);
        2'h2: lid_thr = 8'({1'b0, i_meas.thr} >> 2);
        2'h3: lid_thr = 8'({1'b0, i_meas.thr} >> 1);
      endcase
    end
  end

  assign lid_hit[0] = i_meas.valid && i_meas.sensor == 4'hd && i_meas.delta > lid_thr;
  assign lid_hit[1] = i_meas.valid && i_meas.sensor == 4'he && i_meas.delta > lid_thr;
  assign recal_fin = |(o_recal_req & i_recal_done & ~recal_set);
  assign ev = {recal_fin, |lid_hit, rpt_ev, extra_ev};
  assign o_irq = |(irq_st_r & mask_r);

  always_comb begin
    speed_nxt = speed_r;
    lid4_nxt = lid4_r;
    mask_nxt = mask_r;
    rpt_nxt = rpt_r;
    irq_st_nxt = irq_st_r;
    lid_st_nxt = lid_st_r;
    if (wr_ok) begin
      case (aw_i_r)
        scv_pkg::IDX_LID4: lid4_nxt = {4'h0, w_d_r[3:0]};
        scv_pkg::IDX_SPEED: speed_nxt = w_d_r;
        scv_pkg::IDX_IRQ_STAT: irq_st_nxt = irq_st_r & ~w_d_r[3:0];
        scv_pkg::IDX_IRQ_MASK: mask_nxt = w_d_r[3:0];
        scv_pkg::IDX_LID_STAT: lid_st_nxt = lid_st_r & ~w_d_r[1:0];
        scv_pkg::IDX_RPT_RATE: rpt_nxt = w_d_r;
        default: rpt_nxt = rpt_r;
      endcase
    end
    irq_st_nxt = irq_st_nxt | ev;
    lid_st_nxt = lid_st_nxt | lid_hit;
  end

  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      speed_r <= scv_pkg::SPEED_RST;
      lid4_r <= scv_pkg::LID4_RST;
      mask_r <= scv_pkg::MASK_RST;
      rpt_r <= scv_pkg::RPT_RATE_RST;
      irq_st_r <= 4'h0;
      lid_st_r <= 2'h0;
    end else begin
      speed_r <= speed_nxt;
      lid4_r <= lid4_nxt;
      mask_r <= mask_nxt;
      rpt_r <= rpt_nxt;
      irq_st_r <= irq_st_nxt;
      lid_st_r <= lid_st_nxt;
    end
  end

  // ----------------------------------------
  // Forced recalibration, bit 7 group, bits 6-0 sensors 7-1
  // ----------------------------------------
  for (genvar g = 0; g < 8; g++) begin : g_recal
    assign recal_set[g] = wr_ok && aw_i_r == scv_pkg::IDX_RECAL && w_d_r[g];
    scv_recal_bit u_bit (
      .i_sys_clk(i_sys_clk),
      .i_rst(i_rst),
      .i_set(recal_set[g]),
      .i_done(i_recal_done[g]),
      .o_busy(o_recal_req[g])
    );
  end

  // ----------------------------------------
  // Measurement cycle and slide acceleration
  // ----------------------------------------
  scv_tick #(.DIV(MEAS_CYCLES)) u_tick (
    .i_sys_clk(i_sys_clk),
    .i_rst(i_rst),
    .o_tick(tick)
  );

  always_comb begin
    unique case (speed_r.slide_time_limit)
      2'h0: lim = scv_pkg::LIM0_MEAS;
      2'h1: lim = scv_pkg::LIM1_MEAS;
      2'h2: lim = scv_pkg::LIM2_MEAS;
      2'h3: lim = scv_pkg::LIM3_MEAS;
    endcase
  end

  always_comb begin
    st_nxt = st_r;
    t_nxt = t_r;
    left_nxt = left_r;
    extra_ev = 1'b0;
    unique case (st_r)
      scv_pkg::SL_IDLE: begin
        if (i_slide.step) begin
          st_nxt = scv_pkg::SL_RUN;
          t_nxt = 5'h00;
        end
      end
      scv_pkg::SL_RUN: begin
        if (tick && t_r != 5'h1f) begin
          t_nxt = t_r + 5'h01;
        end
        if (i_slide.done) begin
          if (6'({t_r, 1'b0}) < 6'(lim)) begin
            left_nxt = speed_r.max_extra_irq;
          end else if (7'({t_r, 2'b00}) < 7'(lim) * 7'h03) begin
            left_nxt = speed_r.max_extra_irq >> 1;
          end else if (t_r <= lim) begin
            left_nxt = {2'h0, speed_r.max_extra_irq[2]};
          end else begin
            left_nxt = 3'h0;
          end
          if (speed_r.accel_extra_irq_enable && left_nxt != 3'h0) begin
            st_nxt = scv_pkg::SL_EMIT;
          end else begin
            st_nxt = scv_pkg::SL_IDLE;
          end
        end
      end
      scv_pkg::SL_EMIT: begin
        if (tick) begin
          extra_ev = 1'b1;
          left_nxt = left_r - 3'h1;
          if (left_r == 3'h1) begin
            st_nxt = scv_pkg::SL_IDLE;
          end
        end
      end
      default: st_nxt = scv_pkg::SL_IDLE;
    endcase
  end

  // ----------------------------------------
  // Slide speed and repeat interval
  // ----------------------------------------
  always_comb begin
    win_nxt = win_r;
    cnt_nxt = (i_slide.step && cnt_r != 3'h7) ? cnt_r + 3'h1 : cnt_r;
    spd_nxt = spd_r;
    if (tick) begin
      win_nxt = win_r + 2'h1;
      if (win_r == scv_pkg::WIN_MEAS - 2'h1) begin
        win_nxt = 2'h0;
        spd_nxt = cnt_nxt;
        cnt_nxt = 3'h0;
      end
    end
    iv_nxt = 8'h01;
    unique case (spd_r)
      3'h4: iv_nxt = (speed_r.repeat_speedup_scale == 2'h3) ? 8'h02 : 8'h01;
      3'h3: iv_nxt = speed_r.repeat_speedup_scale[1] ? 8'(speed_r.repeat_speedup_scale) : 8'h01;
      3'h2: iv_nxt = 8'(speed_r.repeat_speedup_scale) + 8'h01;
      3'h1, 3'h0: iv_nxt = rpt_r;
      default: iv_nxt = 8'h01;
    endcase
    if (spd_r > 3'h1 && speed_r.repeat_speedup_scale != 2'h3 && rpt_r < iv_nxt) begin
      iv_nxt = rpt_r;
    end
    rc_nxt = rc_r;
    rpt_ev = 1'b0;
    if (!i_slide.hold) begin
      rc_nxt = 8'h00;
    end else if (tick) begin
      rc_nxt = rc_r + 8'h01;
      if (rc_r + 8'h01 >= o_repeat_cycles) begin
        rpt_ev = 1'b1;
        rc_nxt = 8'h00;
      end
    end
  end

  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      st_r <= scv_pkg::SL_IDLE;
      t_r <= 5'h00;
      left_r <= 3'h0;
      win_r <= 2'h0;
      cnt_r <= 3'h0;
      spd_r <= 3'h0;
      o_repeat_cycles <= scv_pkg::RPT_RATE_RST;
      rc_r <= 8'h00;
      o_slide_irq <= 1'b0;
    end else begin
      st_r <= st_nxt;
      t_r <= t_nxt;
      left_r <= left_nxt;
      win_r <= win_nxt;
      cnt_r <= cnt_nxt;
      spd_r <= spd_nxt;
      o_repeat_cycles <= iv_nxt;
      rc_r <= rc_nxt;
      o_slide_irq <= extra_ev | rpt_ev;
    end
  end

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (i_rst);

  sequence s_slide_end;
    st_r == scv_pkg::SL_RUN && i_slide.done;
  endsequence

  a_lid_fields_hold: assert property (wr_ok && aw_i_r == scv_pkg::IDX_LID4 |=>
    lid4_r == {4'h0, $past(w_d_r[3:0])})
    else $error("lid threshold fields not stored");
  a_accel_gate: assert property (s_slide_end ##1 st_r == scv_pkg::SL_EMIT |->
    $past(speed_r.accel_extra_irq_enable))
    else $error("extra interrupts while disabled");
  a_extra_cap: assert property ($rose(st_r == scv_pkg::SL_EMIT) |-> left_r <= $past(speed_r.max_extra_irq))
    else $error("extra interrupt count above cap");
  a_fast_slide_full: assert property (s_slide_end and (speed_r.accel_extra_irq_enable && speed_r.max_extra_irq != 3'h0 &&
    6'({t_r, 1'b0}) < 6'(lim)) |=> st_r == scv_pkg::SL_EMIT && left_r == $past(speed_r.max_extra_irq))
    else $error("fast slide did not load full count");
  a_slow_slide_quiet: assert property (s_slide_end and (t_r > lim) |=>
    st_r == scv_pkg::SL_IDLE ##1 !extra_ev)
    else $error("slow slide produced extra interrupts");
  a_burst_interval: assert property (spd_r >= 3'h5 |=> o_repeat_cycles == 8'h01)
    else $error("five sensor interval not one cycle");
  a_scale_fixed: assert property (spd_r == 3'h2 && speed_r.repeat_speedup_scale == 2'h3 |=>
    o_repeat_cycles == 8'h04)
    else $error("scale three interval not fixed");
  a_recal_clears: assert property (o_recal_req[0] && i_recal_done[0] && !recal_set[0] |=> !o_recal_req[0])
    else $error("recal bit not cleared on completion");
  a_recal_no_abort: assert property (o_recal_req[0] && !i_recal_done[0] |=> o_recal_req[0])
    else $error("recal aborted before completion");
  a_lid_status_set: assert property (lid_hit[0] |=> lid_st_r[0] && irq_st_r[scv_pkg::IRQ_LID])
    else $error("lid hit did not set status");
endmodule : scv_slider_ctrl
`default_nettype wire

/* testbench/scv_front_model.sv */
`timescale 1ns/10ps
`default_nettype none
// ----------------------------------------
// Front end: answers each recalibration request after a delay
// ----------------------------------------
module scv_front_model #(
  parameter int unsigned DLY = 30
) (
  // Clock and reset
  input wire logic i_sys_clk,
  input wire logic i_rst,
  // Recalibration handshake
  input wire logic [7:0] i_recal_req,
  output logic [7:0] o_recal_done
);
  logic [7:0] cnt_r [8];
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      o_recal_done <= 8'h00;
      for (int k = 0; k < 8; k++) cnt_r[k] <= 8'h00;
    end else begin
      for (int k = 0; k < 8; k++) begin
        o_recal_done[k] <= 1'b0;
        if (!i_recal_req[k] || o_recal_done[k]) cnt_r[k] <= 8'h00;
        else if (cnt_r[k] == 8'(DLY + k)) o_recal_done[k] <= 1'b1;
        else cnt_r[k] <= cnt_r[k] + 8'h01;
      end
    end
  end
endmodule : scv_front_model
`default_nettype wire

/* testbench/scv_slider_ctrl_tb.sv */
`timescale 1ns/10ps
`default_nettype none
module scv_slider_ctrl_tb;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [9:0] awaddr = 10'h000, araddr = 10'h000;
  logic [31:0] wdata = 32'h0, rd;
  logic [3:0] wstrb = 4'h0;
  logic [1:0] rs;
  logic o_awready, o_wready, o_bvalid, o_arready, o_rvalid, o_slide_irq, o_irq;
  logic [1:0] o_bresp, o_rresp;
  logic [31:0] o_rdata;
  logic [7:0] recal_done, o_recal_req, o_repeat_cycles;
  scv_pkg::scv_meas_s meas = '0;
  scv_pkg::scv_slide_s slide = '0;
  int miscompares = 0, n_checks = 0, c, cyc = 0;
  localparam int WIN_CYC = int'(scv_pkg::WIN_MEAS) * 8;
  logic [19:0] rrow [6] = '{{10'h0f4, 8'h0a, 2'h0}, {10'h0f8, 8'hc5, 2'h0}, {10'h0fc, 8'h00, 2'h0},
    {10'h144, 8'h00, 2'h0}, {10'h14c, 8'h03, 2'h0}, {10'h100, 8'h00, 2'h2}};
  logic [19:0] xrow [10] = '{20'hc5034, 20'hc50a2, 20'hc50d1, 20'hc5160, 20'h45030, 20'hc1091,
    20'hcd122, 20'hf5037, 20'hf50a3, 20'h950a0};
  logic [15:0] prow [6] = '{16'h1202, 16'h2302, 16'h3204, 16'h0501, 16'h3402, 16'h1103};

  always #50 sys_clk = ~sys_clk;

  // Cycles since reset release, so a speed burst starts at a window boundary
  always @(posedge sys_clk) cyc <= rst ? 0 : cyc + 1;

  scv_slider_ctrl #(.MEAS_CYCLES(8)) u_dut (.i_sys_clk(sys_clk), .i_rst(rst),
    .i_awvalid(awvalid), .o_awready(o_awready), .i_awaddr(awaddr), .i_wvalid(wvalid), .o_wready(o_wready),
    .i_wdata(wdata), .i_wstrb(wstrb), .o_bvalid(o_bvalid), .i_bready(bready), .o_bresp(o_bresp),
    .i_arvalid(arvalid), .o_arready(o_arready), .i_araddr(araddr), .o_rvalid(o_rvalid), .i_rready(rready),
    .o_rdata(o_rdata), .o_rresp(o_rresp), .i_meas(meas), .i_slide(slide), .i_recal_done(recal_done),
    .o_recal_req(o_recal_req), .o_repeat_cycles(o_repeat_cycles), .o_slide_irq(o_slide_irq), .o_irq(o_irq));
  scv_front_model #(.DLY(30)) u_fe (.i_sys_clk(sys_clk), .i_rst(rst), .i_recal_req(o_recal_req),
    .o_recal_done(recal_done));

  // ----------------------------------------
  // Bus, slide and check tasks
  // ----------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic axi_wr(input logic [9:0] a, input logic [7:0] d, output logic [1:0] r);
    int n;
    logic ad, wd, got;
    n = 0; ad = 0; wd = 0; got = 0; r = 2'h0;
    @(posedge sys_clk);
    awvalid <= 1'b1; wvalid <= 1'b1; awaddr <= a; wdata <= {24'h0, d}; wstrb <= 4'h1; bready <= 1'b1;
    while (!got && n < 50) begin
      @(negedge sys_clk);
      if (awvalid && o_awready) ad = 1;
      if (wvalid && o_wready) wd = 1;
      if (o_bvalid) begin got = 1; r = o_bresp; end
      @(posedge sys_clk);
      if (ad) awvalid <= 1'b0;
      if (wd) wvalid <= 1'b0;
      n++;
    end
    bready <= 1'b0;
    if (!got) begin
      miscompares++;
      $display("[FAIL] t=%0t addr=%h got=%h exp=%h", $time, a, got, 1'b1);
    end
  endtask : axi_wr

  task automatic axi_rd(input logic [9:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    logic ad, got;
    n = 0; ad = 0; got = 0; d = 32'h0; r = 2'h0;
    @(posedge sys_clk);
    arvalid <= 1'b1; araddr <= a; rready <= 1'b1;
    while (!got && n < 50) begin
      @(negedge sys_clk);
      if (arvalid && o_arready) ad = 1;
      if (o_rvalid) begin got = 1; d = o_rdata; r = o_rresp; end
      @(posedge sys_clk);
      if (ad) arvalid <= 1'b0;
      n++;
    end
    rready <= 1'b0;
    if (!got) begin
      miscompares++;
      $display("[FAIL] t=%0t addr=%h got=%h exp=%h", $time, a, got, 1'b1);
    end
  endtask : axi_rd

  task automatic slide_run(input int t, output int cnt);
    @(posedge sys_clk); slide.step <= 1'b1;
    @(posedge sys_clk); slide.step <= 1'b0;
    repeat (t * 8 - 1) @(posedge sys_clk);
    slide.done <= 1'b1;
    @(posedge sys_clk); slide.done <= 1'b0;
    cnt = 0;
    repeat (120) begin
      @(negedge sys_clk);
      if (o_slide_irq === 1'b1) cnt++;
    end
  endtask : slide_run

  task automatic finish_test();
    $display("checks=%0d miscompares=%0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : finish_test

  initial begin
    repeat (60000) @(posedge sys_clk);
    miscompares++;
    finish_test();
  end

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    repeat (3) @(posedge sys_clk);
    rst <= 1'b0;
    for (int i = 0; i < 6; i++) begin
      axi_rd(rrow[i][19:10], rd, rs);
      chk(rd, {24'h0, rrow[i][9:2]});
      chk(32'(rs), 32'(rrow[i][1:0]));
    end
    axi_wr(10'h100, 8'h55, rs);
    chk(32'(rs), 32'(scv_pkg::RESP_SLVERR));
    for (int i = 0; i < 10; i++) begin
      axi_wr(10'h0f8, xrow[i][19:12], rs);
      slide_run(int'(xrow[i][11:4]), c);
      chk(32'(c), 32'(xrow[i][3:0]));
    end
    for (int i = 0; i < 6; i++) begin
      axi_wr(10'h0f8, {6'h31, prow[i][13:12]}, rs);
      @(posedge sys_clk); slide.hold <= 1'b1;
      while (cyc % WIN_CYC != 0) @(posedge sys_clk);
      for (int s = 0; s < int'(prow[i][11:8]); s++) begin
        slide.step <= 1'b1;
        @(posedge sys_clk); slide.step <= 1'b0;
        @(posedge sys_clk);
      end
      for (int w = 0; w < 40 && o_repeat_cycles !== prow[i][7:0]; w++) @(negedge sys_clk);
      chk(32'(o_repeat_cycles), 32'(prow[i][7:0]));
      @(posedge sys_clk); slide.hold <= 1'b0; slide.done <= 1'b1;
      @(posedge sys_clk); slide.done <= 1'b0;
      repeat (120) @(posedge sys_clk);
    end
    axi_wr(10'h0f4, 8'h0c, rs);
    axi_rd(10'h0f4, rd, rs);
    chk(rd, 32'h0000000c);
    @(posedge sys_clk); meas <= '{1'b1, 4'hd, 8'h05, 7'h40};
    @(posedge sys_clk); meas <= '{1'b1, 4'he, 8'h20, 7'h40};
    @(posedge sys_clk); meas <= '0;
    axi_rd(10'h148, rd, rs);
    chk(rd, 32'h00000001);
    @(posedge sys_clk); meas <= '{1'b1, 4'he, 8'h21, 7'h40};
    @(posedge sys_clk); meas <= '0;
    axi_rd(10'h148, rd, rs);
    chk(rd, 32'h00000003);
    axi_wr(10'h0fc, 8'h81, rs);
    @(negedge sys_clk);
    chk(32'(o_recal_req), 32'h81);
    axi_wr(10'h0fc, 8'h00, rs);
    axi_rd(10'h0fc, rd, rs);
    chk(rd, 32'h00000081);
    for (int w = 0; w < 100 && o_recal_req !== 8'h00; w++) @(posedge sys_clk);
    axi_rd(10'h0fc, rd, rs);
    chk(rd, 32'h00000000);
    axi_rd(10'h140, rd, rs);
    chk(rd, 32'h0000000f);
    axi_wr(10'h140, 8'h0f, rs);
    axi_wr(10'h144, 8'h01, rs);
    axi_wr(10'h0f8, 8'hc5, rs);
    slide_run(3, c);
    chk(32'(o_irq), 32'h1);
    axi_wr(10'h140, 8'h0f, rs);
    @(negedge sys_clk);
    chk(32'(o_irq), 32'h0);
    axi_wr(10'h144, 8'h00, rs);
    slide_run(3, c);
    axi_rd(10'h140, rd, rs);
    chk(32'(rd[0]), 32'h1);
    chk(32'(o_irq), 32'h0);
    axi_wr(10'h0f8, 8'h45, rs);
    @(posedge sys_clk); rst <= 1'b1;
    @(negedge sys_clk);
    chk(32'({o_recal_req, o_repeat_cycles}), 32'h0003);
    @(posedge sys_clk); rst <= 1'b0;
    axi_rd(10'h0f8, rd, rs);
    chk(rd, 32'h000000c5);
    axi_rd(10'h0f4, rd, rs);
    chk(rd, 32'h0000000a);
    finish_test();
  end
endmodule : scv_slider_ctrl_tb
`default_nettype wire
